// *** src/sas_defs.svh ***
// register map, field positions, reset values and phase counts of the converter sequencer
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

`define SAS_OFF_CONVERTER_CONTROL 12'h000
`define SAS_OFF_RESULT_HIGH 12'h004
`define SAS_OFF_CONVERTER_CONTROL_TWO 12'h008
`define SAS_OFF_STATUS 12'h00c
`define SAS_OFF_RESULT_FULL 12'h010

`define SAS_CTL_RES_B1 7
`define SAS_CTL_RES_B0 6
`define SAS_CTL_EXT_EN 5
`define SAS_CTL_DONE 4
`define SAS_CTL_START 3
`define SAS_CTL_CHAN_HI 1
`define SAS_CTL_CHAN_LO 0
`define SAS_CTL2_CHAN2 2

`define SAS_CTL_RST 8'h00
`define SAS_CTL2_RST 8'h00
`define SAS_RESULT_RST 10'h000

`define SAS_MC_CLKS 4
`define SAS_INIT_MC 2
`define SAS_SAMPLE_MC 8
`define SAS_BIT_MC 4
`define SAS_NBITS 10
`define SAS_TOTAL_MC 52
`define SAS_SAR_TOP 10'h200

`endif

// *** src/sas_pkg.sv ***
// types shared by the converter sequencer and its approximation register
package sas_pkg;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_INIT,
    PH_SAMPLE,
    PH_CONV,
    PH_TAIL
  } sas_phase_t;

  typedef struct packed {
    logic [9:0] code;
    logic [9:0] mask;
  } sas_sar_q_t;

  typedef struct packed {
    logic [9:0] code;
    logic last;
  } sas_sar_out_t;

  typedef struct packed {
    logic load;
    logic decide;
    logic cmp_bit;
  } sas_sar_cmd_t;

  typedef struct packed {
    sas_phase_t phase;
    logic [7:0] mc_div;
    logic [5:0] ph_cnt;
    logic [2:0] trial_cnt;
    logic cmd;
    logic busy;
    logic done;
    logic ext_en;
    logic [2:0] chan;
    logic [9:0] result;
    logic trig_s1;
    logic trig_s2;
    logic trig_prev;
    logic cmp_s1;
    logic cmp_s2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sample_en;
    sas_sar_cmd_t sar_cmd;
  } sas_q_t;

endpackage

// *** src/sas_sar.sv ***
// ten-bit successive approximation register with one trial bit at a time
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.svh"

module sas_sar (
  input wire logic clk,
  input wire logic rst_n,
  input wire sas_pkg::sas_sar_cmd_t cmd,
  output var sas_pkg::sas_sar_out_t sar_out
);

  sas_pkg::sas_sar_q_t q_r;
  sas_pkg::sas_sar_q_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (cmd.load) begin
      // only the top bit is set for the first trial
      q_nxt.code = `SAS_SAR_TOP;
      q_nxt.mask = `SAS_SAR_TOP;
    end else if (cmd.decide && (q_r.mask != 10'h000)) begin
      // keep the trial bit when the input is above the dac voltage
      q_nxt.code = cmd.cmp_bit ? q_r.code : (q_r.code & ~q_r.mask);
      q_nxt.mask = q_r.mask >> 1;
      q_nxt.code = q_nxt.code | q_nxt.mask;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sar_out.code = q_r.code;
  assign sar_out.last = (q_r.mask == 10'h001);

endmodule
`default_nettype wire

// *** src/sas_sequencer.sv ***
// successive approximation converter sequencer with apb register bank
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.svh"

module sas_sequencer #(
  parameter int MC_CLKS = `SAS_MC_CLKS,
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_trigger_pin,
  input wire logic comparator_in,
  input wire logic idle_mode,
  input wire logic power_down_mode,
  output logic [2:0] channel_sel,
  output logic [9:0] dac_code,
  output logic sample_en,
  output logic conversion_done_flag
);

  localparam int TAIL_MC =
    `SAS_TOTAL_MC - (`SAS_INIT_MC - 1) - `SAS_SAMPLE_MC - `SAS_NBITS * `SAS_BIT_MC;
  localparam logic [7:0] MC_LAST = 8'(MC_CLKS - 1);
  localparam logic [5:0] INIT_LAST = 6'(`SAS_INIT_MC - 1);
  localparam logic [5:0] SAMPLE_LAST = 6'(`SAS_SAMPLE_MC - 1);
  localparam logic [5:0] BITS_LAST = 6'(`SAS_NBITS - 1);
  localparam logic [2:0] TRIAL_LAST = 3'(`SAS_BIT_MC - 1);
  localparam logic [5:0] TAIL_LAST = 6'(TAIL_MC - 1);

  localparam int SEL_CTL = 0;
  localparam int SEL_RES_HI = 1;
  localparam int SEL_CTL2 = 2;
  localparam int SEL_STAT = 3;
  localparam int SEL_RES = 4;

  if ((MC_CLKS < 2) || (MC_CLKS > 255)) begin : g_chk_mc
    $error("MC_CLKS must lie between 2 and 255");
  end
  if ((ADDR_W < 5) || (ADDR_W > 12)) begin : g_chk_addr
    $error("ADDR_W must lie between 5 and 12");
  end
  if ((TAIL_MC < 1) || (`SAS_BIT_MC > 8)) begin : g_chk_phase
    $error("phase counts do not fit the sequencer");
  end

  // one-hot register select, used by both the read and the write path
  function automatic logic [4:0] reg_decode(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    reg_decode = 5'h00;
    case (a)
      `SAS_OFF_CONVERTER_CONTROL: reg_decode[SEL_CTL] = 1'b1;
      `SAS_OFF_RESULT_HIGH: reg_decode[SEL_RES_HI] = 1'b1;
      `SAS_OFF_CONVERTER_CONTROL_TWO: reg_decode[SEL_CTL2] = 1'b1;
      `SAS_OFF_STATUS: reg_decode[SEL_STAT] = 1'b1;
      `SAS_OFF_RESULT_FULL: reg_decode[SEL_RES] = 1'b1;
      default: reg_decode = 5'h00;
    endcase
  endfunction

  logic [1:0] rst_sync_r;
  logic rst_n_s;
  sas_pkg::sas_q_t q_r;
  sas_pkg::sas_q_t q_nxt;
  sas_pkg::sas_sar_out_t sar_out;

  // async assert, synchronous release
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_r[1];

  sas_sar u_sar (
    .clk(sys_clk),
    .rst_n(rst_n_s),
    .cmd(q_r.sar_cmd),
    .sar_out(sar_out)
  );

  logic mc_tick;
  logic ext_edge;
  logic abort;
  logic apb_acc;
  logic wr_go;
  logic [4:0] sel;
  logic [7:0] ctl_rd;

  always_comb begin
    q_nxt = q_r;
    q_nxt.sar_cmd.load = 1'b0;
    q_nxt.sar_cmd.decide = 1'b0;

    // trigger and comparator pins pass two flops before use
    q_nxt.trig_s1 = start_trigger_pin;
    q_nxt.trig_s2 = q_r.trig_s1;
    q_nxt.cmp_s1 = comparator_in;
    q_nxt.cmp_s2 = q_r.cmp_s1;

    mc_tick = (q_r.mc_div == MC_LAST);
    q_nxt.mc_div = mc_tick ? 8'h00 : 8'(q_r.mc_div + 8'h01);

    // pin edge looked at only at machine cycle ends; a pulse of MC_CLKS cycles is always seen
    ext_edge = q_r.ext_en && q_r.trig_s2 && !q_r.trig_prev;
    if (mc_tick) begin
      q_nxt.trig_prev = q_r.trig_s2;
    end

    abort = idle_mode || power_down_mode;

    // apb: one wait state, read data latched in the first access cycle
    apb_acc = psel && penable;
    sel = reg_decode(paddr);
    wr_go = apb_acc && q_r.pready && pwrite;
    ctl_rd = {q_r.result[1:0], q_r.ext_en, q_r.done, q_r.busy, 1'b0, q_r.chan[1:0]};
    q_nxt.pready = apb_acc && !q_r.pready;
    q_nxt.pslverr = apb_acc && !q_r.pready && (sel == 5'h00);
    if (apb_acc && !q_r.pready) begin
      case (1'b1)
        sel[SEL_CTL]: q_nxt.prdata = {24'h000000, ctl_rd};
        sel[SEL_RES_HI]: q_nxt.prdata = {24'h000000, q_r.result[9:2]};
        sel[SEL_CTL2]: q_nxt.prdata = {29'h00000000, q_r.chan[2], 2'b00};
        sel[SEL_STAT]: q_nxt.prdata = {26'h0000000, q_r.phase, q_r.cmd, q_r.busy,
          q_r.sample_en};
        sel[SEL_RES]: q_nxt.prdata = {22'h000000, q_r.result};
        default: q_nxt.prdata = 32'h00000000;
      endcase
    end else if (!apb_acc) begin
      q_nxt.prdata = 32'h00000000;
    end

    if (wr_go && sel[SEL_CTL]) begin
      q_nxt.ext_en = pwdata[`SAS_CTL_EXT_EN];
      q_nxt.chan[1:0] = pwdata[`SAS_CTL_CHAN_HI:`SAS_CTL_CHAN_LO];
      // a start written while a conversion runs is dropped, not queued
      if (pwdata[`SAS_CTL_START] && (q_r.phase == sas_pkg::PH_IDLE) && !abort) begin
        q_nxt.cmd = 1'b1;
      end
      // writing zero clears done, writing one leaves it
      if (!pwdata[`SAS_CTL_DONE]) begin
        q_nxt.done = 1'b0;
      end
    end
    if (wr_go && sel[SEL_CTL2]) begin
      q_nxt.chan[2] = pwdata[`SAS_CTL2_CHAN2];
    end

    case (q_r.phase)
      sas_pkg::PH_IDLE: begin
        if (mc_tick && !abort && (q_r.cmd || ext_edge)) begin
          q_nxt.phase = sas_pkg::PH_INIT;
          q_nxt.ph_cnt = 6'h00;
          q_nxt.cmd = 1'b0;
          q_nxt.done = 1'b0;
        end
      end
      sas_pkg::PH_INIT: begin
        if (mc_tick) begin
          if (q_r.ph_cnt == 6'h00) begin
            q_nxt.busy = 1'b1;
          end
          if (q_r.ph_cnt == INIT_LAST) begin
            q_nxt.phase = sas_pkg::PH_SAMPLE;
            q_nxt.ph_cnt = 6'h00;
            q_nxt.sample_en = 1'b1;
          end else begin
            q_nxt.ph_cnt = 6'(q_r.ph_cnt + 6'h01);
          end
        end
      end
      sas_pkg::PH_SAMPLE: begin
        if (mc_tick) begin
          if (q_r.ph_cnt == SAMPLE_LAST) begin
            q_nxt.phase = sas_pkg::PH_CONV;
            q_nxt.ph_cnt = 6'h00;
            q_nxt.trial_cnt = 3'h0;
            q_nxt.sample_en = 1'b0;
            q_nxt.sar_cmd.load = 1'b1;
          end else begin
            q_nxt.ph_cnt = 6'(q_r.ph_cnt + 6'h01);
          end
        end
      end
      sas_pkg::PH_CONV: begin
        if (mc_tick) begin
          if (q_r.trial_cnt == TRIAL_LAST) begin
            // comparator taken once, at the close of the trial
            q_nxt.sar_cmd.decide = 1'b1;
            q_nxt.sar_cmd.cmp_bit = q_r.cmp_s2;
            q_nxt.trial_cnt = 3'h0;
            if (q_r.ph_cnt == BITS_LAST) begin
              q_nxt.phase = sas_pkg::PH_TAIL;
              q_nxt.ph_cnt = 6'h00;
            end else begin
              q_nxt.ph_cnt = 6'(q_r.ph_cnt + 6'h01);
            end
          end else begin
            q_nxt.trial_cnt = 3'(q_r.trial_cnt + 3'h1);
          end
        end
      end
      sas_pkg::PH_TAIL: begin
        if (mc_tick) begin
          if (q_r.ph_cnt == TAIL_LAST) begin
            // result only moves here, so a finished one survives idle entry
            q_nxt.result = sar_out.code;
            q_nxt.done = 1'b1;
            q_nxt.busy = 1'b0;
            q_nxt.phase = sas_pkg::PH_IDLE;
            q_nxt.ph_cnt = 6'h00;
          end else begin
            q_nxt.ph_cnt = 6'(q_r.ph_cnt + 6'h01);
          end
        end
      end
      default: begin
        q_nxt.phase = sas_pkg::PH_IDLE;
      end
    endcase

    // leaving run mode kills the conversion in flight but never the stored result
    if (abort) begin
      q_nxt.cmd = 1'b0;
      if (q_r.phase != sas_pkg::PH_IDLE) begin
        q_nxt.phase = sas_pkg::PH_IDLE;
        q_nxt.busy = 1'b0;
        q_nxt.sample_en = 1'b0;
        q_nxt.ph_cnt = 6'h00;
        q_nxt.sar_cmd.load = 1'b0;
        q_nxt.sar_cmd.decide = 1'b0;
        q_nxt.done = q_r.done;
        q_nxt.result = q_r.result;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign prdata = q_r.prdata;
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign channel_sel = q_r.chan;
  assign dac_code = sar_out.code;
  assign sample_en = q_r.sample_en;
  assign conversion_done_flag = q_r.done;

endmodule
`default_nettype wire

// *** sim/sas_monitor.sv ***
// port-level assertion checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sas_monitor #(
  parameter int MC_CLKS = 4,
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_trigger_pin,
  input wire logic comparator_in,
  input wire logic idle_mode,
  input wire logic power_down_mode,
  input wire logic [2:0] channel_sel,
  input wire logic [9:0] dac_code,
  input wire logic sample_en,
  input wire logic conversion_done_flag
);
  // ten trials of four machine cycles plus three tail cycles after sampling
  localparam int CLO = 43 * MC_CLKS - 3;
  localparam int CHI = 43 * MC_CLKS + 3;
  logic [11:0] smp_len_r;
  logic [11:0] smp_len_nxt;
  logic wr_ok;
  logic halt;
  assign wr_ok = psel && penable && pready && pwrite;
  assign halt = idle_mode || power_down_mode;
  assign smp_len_nxt = sample_en ? smp_len_r + 12'h001 : 12'h000;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      smp_len_r <= 12'h000;
    end else begin
      smp_len_r <= smp_len_nxt;
    end
  end
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_sample_len: assert property (
    $fell(sample_en) && !$past(halt) |-> smp_len_r == 12'(8 * MC_CLKS))
    else $error("sampling window has the wrong length");
  a_conv_len: assert property (
    $fell(sample_en) && !$past(halt) |-> ##[CLO:CHI] $rose(conversion_done_flag))
    else $error("done not raised on time after sampling");
  a_top_bit_first: assert property (
    $fell(sample_en) && !$past(halt) |-> ##[0:3] dac_code == 10'h200)
    else $error("first trial code is not the top bit alone");
  a_abort_stops: assert property (halt |=> !sample_en)
    else $error("sampling kept on after idle or power-down");
  a_done_kept_idle: assert property (
    conversion_done_flag && halt |=> conversion_done_flag)
    else $error("done lost on idle or power-down");
  a_done_sw_clear: assert property (
    wr_ok && paddr == 'h0 && !pwdata[4] |=> !conversion_done_flag)
    else $error("done not cleared by software write");
  a_done_new_conv: assert property ($rose(sample_en) |-> !conversion_done_flag)
    else $error("done still set in a new conversion");
  a_chan_low: assert property (
    wr_ok && paddr == 'h0 |=> channel_sel[1:0] == $past(pwdata[1:0]))
    else $error("channel low bits do not follow control");
  a_chan_high: assert property (
    wr_ok && paddr == 'h8 |=> channel_sel[2] == $past(pwdata[2]))
    else $error("channel top bit does not follow control two");
  a_busy_read: assert property (
    psel && penable && pready && !pwrite && paddr == 'h0 && sample_en |-> prdata[3])
    else $error("start bit reads 0 while converting");
  c_done: cover property ($rose(conversion_done_flag));
  c_unmapped: cover property (pslverr);
  c_abort: cover property (halt && sample_en);
endmodule
bind sas_sequencer sas_monitor #(.MC_CLKS(MC_CLKS), .ADDR_W(ADDR_W)) sas_monitor_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .start_trigger_pin(start_trigger_pin), .comparator_in(comparator_in),
  .idle_mode(idle_mode), .power_down_mode(power_down_mode), .channel_sel(channel_sel),
  .dac_code(dac_code), .sample_en(sample_en), .conversion_done_flag(conversion_done_flag));
`default_nettype wire

// *** sim/sas_trig_src.sv ***
// external start trigger source: one high pulse of set length per request
`timescale 1ns/1ps
`default_nettype none
module sas_trig_src (
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [7:0] hi_clks,
  output logic pin
);
  logic [7:0] left_r = 8'h00;
  initial pin = 1'b0;
  always @(posedge sys_clk) begin
    if (fire) begin
      pin <= 1'b1;
      left_r <= hi_clks;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
      pin <= (left_r != 8'h01);
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_sar_adc_sequencer.sv ***
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_sequencer;
  localparam int MC = 2;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic start_trigger_pin;
  logic comparator_in = 1'b0;
  logic idle_mode = 1'b0;
  logic power_down_mode = 1'b0;
  logic [2:0] channel_sel;
  logic [9:0] dac_code;
  logic sample_en;
  logic conversion_done_flag;
  logic fire = 1'b0;
  logic [9:0] vin = 10'h000;
  logic [31:0] rd;
  logic er;
  logic [31:0] seed = 32'd90;
  int miscompares = 0;
  int n_checks = 0;
  int n;
  int cyc = 0;
  int t0 = 0;
  int el;
  sas_sequencer #(.MC_CLKS(MC)) sas_sequencer_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_trigger_pin(start_trigger_pin),
    .comparator_in(comparator_in), .idle_mode(idle_mode), .power_down_mode(power_down_mode),
    .channel_sel(channel_sel), .dac_code(dac_code), .sample_en(sample_en),
    .conversion_done_flag(conversion_done_flag));
  sas_trig_src sas_trig_src_i (.sys_clk(sys_clk), .fire(fire), .hi_clks(8'(4 * MC)),
    .pin(start_trigger_pin));
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  // input code stands for mid-step analog level, so keeping on equality is exact
  always @(posedge sys_clk) comparator_in <= (vin >= dac_code);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [9:0] exp_sar(input logic [9:0] v);
    logic [9:0] c;
    c = 10'h000;
    for (int i = 9; i >= 0; i--) begin
      c[i] = 1'b1;
      if (v < c) c[i] = 1'b0;
    end
    return c;
  endfunction
  task wrap_up();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_hi(input bit d, input int lim);
    n = 0;
    while ((d ? conversion_done_flag : sample_en) !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task pulse();
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
  endtask
  task fin(input logic [9:0] v);
    logic [7:0] hi;
    wait_hi(1'b1, 400);
    el = cyc - t0;
    apb(1'b0, 12'h004, 32'h0);
    hi = rd[7:0];
    apb(1'b0, 12'h000, 32'h0);
    chk({hi, rd[7:6]}, exp_sar(v));
    chk(rd[4], 1'b1);
  endtask
  task conv(input logic [2:0] ch, input logic [9:0] v);
    vin <= v;
    apb(1'b1, 12'h008, {29'h0, ch[2], 2'b00});
    apb(1'b1, 12'h000, {28'h0, 2'b10, ch[1:0]});
    t0 = cyc;
    wait_hi(1'b0, 40);
    // channel register updates at the completing edge, so look once sampling runs
    chk(channel_sel, ch);
    chk(n >= 2 * MC - 1 && n <= 3 * MC + 2, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd[3], 1'b1);
    fin(v);
    chk(el >= 53 * MC - 2 && el <= 54 * MC + 2, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(er, 1'b1);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      conv(3'(i), (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : seed[9:0]);
    end
    idle_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    idle_mode <= 1'b0;
    fin(vin);
    apb(1'b1, 12'h000, 32'h0);
    // the clear lands at the completing edge; let it settle before looking
    @(posedge sys_clk);
    chk(conversion_done_flag, 1'b0);
    pulse();
    wait_hi(1'b0, 20);
    chk(n, 20);
    seed = xs(seed);
    vin <= seed[9:0];
    apb(1'b1, 12'h000, 32'h20);
    pulse();
    wait_hi(1'b0, 40);
    chk(n >= 2 * MC && n <= 5 * MC + 3, 1'b1);
    t0 = cyc;
    // a second start by write and by pin while busy must change nothing
    apb(1'b1, 12'h000, 32'h28);
    pulse();
    fin(vin);
    chk(el >= 51 * MC - 2 && el <= 51 * MC + 3, 1'b1);
    wait_hi(1'b0, 60);
    chk(n, 60);
    apb(1'b1, 12'h000, 32'h08);
    wait_hi(1'b0, 40);
    power_down_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    power_down_mode <= 1'b0;
    chk(sample_en, 1'b0);
    wait_hi(1'b1, 150);
    chk(n, 150);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
